// ### rtl/comparator_ctrl_pkg.sv
package comparator_ctrl_pkg;

    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 8;
    localparam logic [7:0]  CTRL_STATUS_OFS   = 8'h00;
    localparam logic [7:0]  CTRL_STATUS_RESET = 8'h00;

    localparam int          BIT_ON            = 7;
    localparam int          BIT_REF_SEL       = 6;
    localparam int          BIT_FLAG          = 5;
    localparam int          BIT_IRQ_EN        = 4;
    localparam int          BIT_LEVEL         = 3;
    localparam int          BIT_PIN_EN        = 2;
    localparam int          MODE_HI           = 1;
    localparam int          MODE_LO           = 0;

    localparam logic [1:0]  MODE_FALL_A       = 2'h0;
    localparam logic [1:0]  MODE_RISE         = 2'h1;
    localparam logic [1:0]  MODE_FALL_B       = 2'h2;
    localparam logic [1:0]  MODE_BOTH         = 2'h3;

    localparam int          SYNC_STAGES       = 2;

endpackage

// ### rtl/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
    parameter int STAGES = comparator_ctrl_pkg::SYNC_STAGES
) (
    // Clock and control
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    input  wire logic clk_en_i,
    // Level
    input  wire logic async_i,
    output logic      sync_o
);
    logic [STAGES-1:0] chain;

    initial begin
        if (STAGES < 2) begin
            $error("level_sync needs at least two stages");
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            chain <= '0;
        end else if (clk_en_i) begin
            chain <= {chain[STAGES-2:0], async_i};
        end
    end

    assign sync_o = chain[STAGES-1];
endmodule

// ### rtl/analog_comparator_ctrl.sv
`timescale 1ns/1ps
module analog_comparator_ctrl #(
    parameter int ADDR_W = comparator_ctrl_pkg::ADDR_W
) (
    // Clock, reset, enable
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire logic              clk_en_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    // Analog side
    input  wire logic              comp_raw_i,
    input  wire logic              stop_mode_i,
    output logic                   comparator_on_o,
    output logic                   reference_input_select_o,
    // Pin and interrupt
    output logic                   comparator_out_pin_o,
    output logic                   comparator_out_pin_oe_o,
    output logic                   irq_o
);
    initial begin
        if (ADDR_W < 8) begin
            $error("ADDR_W must cover the 8-bit offset");
        end
    end

    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic       rise,
                                      input logic       fall);
        case (mode)
            comparator_ctrl_pkg::MODE_FALL_A: edge_hit = fall;
            comparator_ctrl_pkg::MODE_RISE:   edge_hit = rise;
            comparator_ctrl_pkg::MODE_FALL_B: edge_hit = fall;
            comparator_ctrl_pkg::MODE_BOTH:   edge_hit = rise | fall;
            default:                          edge_hit = 1'b0;
        endcase
    endfunction

    // Control and state
    logic       comparator_on;
    logic       reference_input_select;
    logic       compare_event_flag;
    logic       compare_irq_enable;
    logic       output_pin_drive_enable;
    logic [1:0] event_edge_select;
    logic       comparator_level;
    logic       active_q;

    // Decode
    wire        sel_ctrl;
    wire        wr_ctrl;
    wire        rd_ctrl;
    wire        clear_req;
    wire        active;
    wire        sync_level;
    wire        rise;
    wire        fall;
    wire        event_hit;
    wire        next_flag;
    wire        next_level;
    wire  [7:0] ctrl_view;
    wire  [7:0] next_rdata;

    assign sel_ctrl = addr_i == ADDR_W'(comparator_ctrl_pkg::CTRL_STATUS_OFS);
    assign wr_ctrl  = wr_i & sel_ctrl;
    assign rd_ctrl  = rd_i & sel_ctrl;

    assign active = comparator_on & ~stop_mode_i;

    // Polarity fixed by the analog stage
    level_sync #(
        .STAGES (comparator_ctrl_pkg::SYNC_STAGES)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .clk_en_i  (clk_en_i),
        .async_i   (comp_raw_i),
        .sync_o    (sync_level)
    );

    assign next_level = active & sync_level;

    assign rise = active & active_q & next_level & ~comparator_level;
    assign fall = active & active_q & ~next_level & comparator_level;

    assign event_hit = edge_hit(event_edge_select, rise, fall);

    assign clear_req = wr_ctrl & wdata_i[comparator_ctrl_pkg::BIT_FLAG];

    assign next_flag = event_hit | (compare_event_flag & ~clear_req);

    // Live level, zero as soon as disabled
    assign ctrl_view = {comparator_on, reference_input_select,
                        compare_event_flag, compare_irq_enable,
                        comparator_level & comparator_on,
                        output_pin_drive_enable,
                        event_edge_select};

    assign next_rdata = rd_ctrl ? ctrl_view : 8'h00;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            comparator_on           <= comparator_ctrl_pkg::CTRL_STATUS_RESET
                                       [comparator_ctrl_pkg::BIT_ON];
            reference_input_select  <= comparator_ctrl_pkg::CTRL_STATUS_RESET
                                       [comparator_ctrl_pkg::BIT_REF_SEL];
            compare_irq_enable      <= comparator_ctrl_pkg::CTRL_STATUS_RESET
                                       [comparator_ctrl_pkg::BIT_IRQ_EN];
            output_pin_drive_enable <= comparator_ctrl_pkg::CTRL_STATUS_RESET
                                       [comparator_ctrl_pkg::BIT_PIN_EN];
            event_edge_select       <= comparator_ctrl_pkg::CTRL_STATUS_RESET
                                       [comparator_ctrl_pkg::MODE_HI:
                                        comparator_ctrl_pkg::MODE_LO];
        end else if (clk_en_i && wr_ctrl) begin
            comparator_on           <= wdata_i[comparator_ctrl_pkg::BIT_ON];
            reference_input_select  <= wdata_i[comparator_ctrl_pkg::BIT_REF_SEL];
            compare_irq_enable      <= wdata_i[comparator_ctrl_pkg::BIT_IRQ_EN];
            output_pin_drive_enable <= wdata_i[comparator_ctrl_pkg::BIT_PIN_EN];
            event_edge_select       <= wdata_i[comparator_ctrl_pkg::MODE_HI:
                                               comparator_ctrl_pkg::MODE_LO];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            compare_event_flag <= 1'b0;
            comparator_level   <= 1'b0;
            active_q           <= 1'b0;
        end else if (clk_en_i) begin
            compare_event_flag <= next_flag;
            comparator_level   <= next_level;
            active_q           <= active;
        end
    end

    // Stop forces comparator_on_o and the level low but leaves the control bits intact; reset restores
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_o                  <= 8'h00;
            irq_o                    <= 1'b0;
            comparator_on_o          <= 1'b0;
            reference_input_select_o <= 1'b0;
            comparator_out_pin_o     <= 1'b0;
            comparator_out_pin_oe_o  <= 1'b0;
        end else if (clk_en_i) begin
            rdata_o                  <= next_rdata;
            irq_o                    <= next_flag & (wr_ctrl ?
                                        wdata_i[comparator_ctrl_pkg::BIT_IRQ_EN]
                                        : compare_irq_enable);
            comparator_on_o          <= wr_ctrl ?
                                        wdata_i[comparator_ctrl_pkg::BIT_ON] &
                                        ~stop_mode_i : active;
            reference_input_select_o <= wr_ctrl ?
                                        wdata_i[comparator_ctrl_pkg::BIT_REF_SEL]
                                        : reference_input_select;
            comparator_out_pin_o     <= output_pin_drive_enable & next_level;
            comparator_out_pin_oe_o  <= output_pin_drive_enable;
        end
    end

    sequence s_raw_high_active;
        (clk_en_i && active && comp_raw_i)[*3];
    endsequence

    sequence s_flag_clear_write;
        clk_en_i && clear_req && !event_hit;
    endsequence

    a_flag_set_event: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        (clk_en_i && event_hit) |=> compare_event_flag)
        else $error("flag not set after compare event");

    a_flag_w1c_clear: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        s_flag_clear_write |=> !compare_event_flag)
        else $error("flag not cleared by write of one");

    a_flag_zero_keeps: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        (clk_en_i && compare_event_flag && wr_ctrl &&
         !wdata_i[comparator_ctrl_pkg::BIT_FLAG]) |=> compare_event_flag)
        else $error("flag lost on write of zero");

    a_set_beats_clear: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        (clk_en_i && clear_req && event_hit) |=> compare_event_flag)
        else $error("clear won over simultaneous set");

    a_irq_tracks_flag: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        irq_o == (compare_event_flag && compare_irq_enable))
        else $error("interrupt does not match flag and enable");

    a_level_off_zero: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        (clk_en_i && !active) |=> !comparator_level)
        else $error("level bit set while comparator off");

    a_level_sync_delay: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        s_raw_high_active |=> comparator_level)
        else $error("level not seen after synchroniser");

    a_read_data_next: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        (clk_en_i && rd_ctrl) |=> rdata_o == $past(ctrl_view))
        else $error("read data wrong in cycle after read");

    a_stop_forces_off: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        (clk_en_i && stop_mode_i) |=> !comparator_on_o && !event_hit)
        else $error("comparator on during stop");

    a_pin_quiet_off: assert property (@(posedge ref_clk_i)
        disable iff (reset_i)
        (clk_en_i && !output_pin_drive_enable) |=>
            !comparator_out_pin_o && !comparator_out_pin_oe_o)
        else $error("pin driven without enable");

endmodule

// ### verification/comparator_model.sv
`timescale 1ns/1ps
module comparator_model #(
    parameter int BANDGAP_MV = 1200
) (
    // Analog levels in millivolts
    input  wire logic [15:0] plus_mv_i,
    input  wire logic [15:0] minus_mv_i,
    // Control from the block
    input  wire logic        on_i,
    input  wire logic        ref_sel_i,
    // Result
    output logic             raw_o
);
    logic [15:0] non_inv;

    assign non_inv = ref_sel_i ? 16'(BANDGAP_MV) : plus_mv_i;
    assign raw_o = on_i && (non_inv > minus_mv_i);
endmodule

// ### verification/analog_comparator_ctrl_tb_top.sv
`timescale 1ns/1ps
module analog_comparator_ctrl_tb_top;
    logic        ref_clk_i;
    logic        reset_i;
    logic        clk_en;
    logic [7:0]  addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic        stop_mode_i;
    logic [7:0]  rdata_o;
    logic        comp_raw;
    logic        on_o;
    logic        ref_sel_o;
    logic        pin_o;
    logic        pin_oe_o;
    logic        irq_o;
    logic [15:0] plus_mv;
    logic [15:0] minus_mv;
    int          n_fail;
    int          check_count;

    analog_comparator_ctrl analog_comparator_ctrl_inst (
        .ref_clk_i                (ref_clk_i),
        .reset_i                  (reset_i),
        .clk_en_i                 (clk_en),
        .addr_i                   (addr_i),
        .wdata_i                  (wdata_i),
        .wr_i                     (wr_i),
        .rd_i                     (rd_i),
        .rdata_o                  (rdata_o),
        .comp_raw_i               (comp_raw),
        .stop_mode_i              (stop_mode_i),
        .comparator_on_o          (on_o),
        .reference_input_select_o (ref_sel_o),
        .comparator_out_pin_o     (pin_o),
        .comparator_out_pin_oe_o  (pin_oe_o),
        .irq_o                    (irq_o)
    );

    comparator_model comparator_model_inst (
        .plus_mv_i  (plus_mv),
        .minus_mv_i (minus_mv),
        .on_i       (on_o),
        .ref_sel_i  (ref_sel_o),
        .raw_o      (comp_raw)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // Change analog levels, then let the synchroniser settle
    task automatic set_in(input logic [15:0] p, input logic [15:0] m);
        @(posedge ref_clk_i);
        plus_mv  <= p;
        minus_mv <= m;
        repeat (6) @(posedge ref_clk_i);
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end

    initial begin
        logic [7:0] md;
        logic       rise;
        logic       fall;
        reset_i = 1'b1;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        stop_mode_i = 1'b0;
        clk_en = 1'b1;
        plus_mv = 16'h01f4;
        minus_mv = 16'h03e8;
        n_fail = 0;
        check_count = 0;
        repeat (8) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd_chk(8'h00, 8'h00);
        wr(8'h05, 8'hff);
        rd_chk(8'h05, 8'h00);
        rd_chk(8'h00, 8'h00);
        $display("test reset and unmapped done");
        for (md = 8'h00; md < 8'h04; md = md + 8'h01) begin
            rise = (md == 8'h01) || (md == 8'h03);
            fall = (md != 8'h01);
            wr(8'h00, 8'ha0 | md);
            repeat (4) @(posedge ref_clk_i);
            set_in(16'h07d0, 16'h03e8);
            rd_chk(8'h00, 8'h88 | md | (rise ? 8'h20 : 8'h00));
            set_in(16'h01f4, 16'h03e8);
            rd_chk(8'h00, 8'h80 | md | (rise | fall ? 8'h20 : 8'h00));
        end
        $display("test edge modes done");
        wr(8'h00, 8'h90);
        chk({7'h00, irq_o}, 8'h01);
        rd_chk(8'h00, 8'hb0);
        wr(8'h00, 8'h80);
        chk({7'h00, irq_o}, 8'h00);
        wr(8'h00, 8'ha0);
        rd_chk(8'h00, 8'h80);
        // Clear write lands on the edge that sees the rising event
        wr(8'h00, 8'h81);
        @(posedge ref_clk_i);
        plus_mv <= 16'h07d0;
        @(posedge ref_clk_i);
        wr(8'h00, 8'ha1);
        rd_chk(8'h00, 8'ha9);
        wr(8'h00, 8'ha0);
        $display("test flag and irq done");
        wr(8'h00, 8'h84);
        set_in(16'h07d0, 16'h03e8);
        chk({6'h00, pin_oe_o, pin_o}, 8'h03);
        rd_chk(8'h00, 8'h8c);
        // Clock enable low freezes the pin despite the input change
        @(posedge ref_clk_i);
        clk_en  <= 1'b0;
        plus_mv <= 16'h01f4;
        repeat (6) @(posedge ref_clk_i);
        #1;
        chk({6'h00, pin_oe_o, pin_o}, 8'h03);
        @(posedge ref_clk_i);
        clk_en <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        #1;
        chk({6'h00, pin_oe_o, pin_o}, 8'h02);
        wr(8'h00, 8'h80);
        // Pin outputs follow the enable register one cycle later
        @(posedge ref_clk_i);
        #1;
        chk({6'h00, pin_oe_o, pin_o}, 8'h00);
        $display("test pin done");
        wr(8'h00, 8'hc0);
        chk({7'h00, ref_sel_o}, 8'h01);
        set_in(16'h07d0, 16'h05dc);
        rd_chk(8'h00, 8'he0);
        set_in(16'h07d0, 16'h03e8);
        wr(8'h00, 8'h40);
        repeat (4) @(posedge ref_clk_i);
        chk({7'h00, on_o}, 8'h00);
        rd_chk(8'h00, 8'h60);
        $display("test bandgap and disable done");
        wr(8'h00, 8'hb0);
        // Level settles high, so stop forces a drop that must not count
        repeat (6) @(posedge ref_clk_i);
        stop_mode_i <= 1'b1;
        set_in(16'h07d0, 16'h03e8);
        chk({7'h00, on_o}, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        stop_mode_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        chk({7'h00, on_o}, 8'h01);
        rd_chk(8'h00, 8'h98);
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd_chk(8'h00, 8'h00);
        $display("test stop and reset done");
        give_verdict();
    end
endmodule
